//--- icc_top.sv
// Interrupt context capture top with APB registers, vector and global ports.
//
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
module icc_top
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [icc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic int_ack_n,
  output logic int_request_n,
  output logic [7:0] int_vector,
  output logic int_vector_valid,
  input wire logic [icc_pkg::NUM_SRC*icc_pkg::BID_W-1:0] bids,
  input wire logic [icc_pkg::NUM_CH*8-1:0] rx_data,
  input wire logic [icc_pkg::NUM_CH*8-1:0] rx_fill,
  input wire logic [icc_pkg::NUM_CH*8-1:0] tx_space,
  input wire logic [icc_pkg::NUM_CH*8-1:0] chan_status,
  output logic [icc_pkg::NUM_CH-1:0] rx_pop,
  output logic [icc_pkg::NUM_CH-1:0] tx_push,
  output logic [7:0] tx_data,
  output logic irq
);
  import icc_pkg::*;

  // ==========================================================================
  // Declarations.
  logic [CTRL_W-1:0] ctrl_r;
  logic [CTRL_W-1:0] ctrl_nxt;
  logic [7:0] vbase_r;
  logic [7:0] vbase_nxt;
  logic [NUM_SRC-1:0] mask_r;
  logic [NUM_SRC-1:0] mask_nxt;
  logic [BID_W-1:0] cap_r;
  logic [BID_W-1:0] cap_nxt;
  logic [7:0] vec_r;
  logic [7:0] vec_nxt;
  logic [NUM_EV-1:0] stat_r;
  logic [NUM_EV-1:0] stat_nxt;
  logic [NUM_EV-1:0] en_r;
  logic [NUM_EV-1:0] en_nxt;
  logic req_prev_r;
  logic req_prev_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic [NUM_CH-1:0] rx_pop_r;
  logic [NUM_CH-1:0] rx_pop_nxt;
  logic [NUM_CH-1:0] tx_push_r;
  logic [NUM_CH-1:0] tx_push_nxt;
  logic [7:0] tx_data_r;
  logic [7:0] tx_data_nxt;
  logic [BID_W-1:0] win;
  logic win_valid;
  logic ack_active;
  logic ack_fall;
  logic setup;
  logic access;
  logic wr;
  logic rd;
  logic hit;
  logic refresh;
  logic capture;
  logic [BID_W-1:0] cap_load;
  logic [NUM_EV-1:0] ev;
  logic [NUM_EV-1:0] clr;
  logic [31:0] rd_data;
  logic ctx_ch;
  logic [3:0] ctx_type;
  logic [7:0] ctx_count;
  logic [NUM_CH-1:0] ctx_onehot;

  // ==========================================================================
  // Submodules.
  icc_ack_sync u_ack
  (
    .mclk(mclk),
    .rst_n(rst_n),
    .int_ack_n(int_ack_n),
    .ack_active(ack_active),
    .ack_fall(ack_fall)
  );

  icc_arbiter u_arb
  (
    .mclk(mclk),
    .rst_n(rst_n),
    .bids(bids),
    .src_mask(mask_r),
    .threshold(ctrl_r[THR_MSB:THR_LSB]),
    .win(win),
    .win_valid(win_valid)
  );

  // ==========================================================================
  // APB phase decode; every access completes without wait states.
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign wr = access & pwrite;
  assign rd = access & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = access & ~hit;

  // Address hit check, read-only and write-only registers included.
  always_comb
  begin
    unique case (paddr)
      OFS_INT_CONTROL, OFS_VECTOR_BASE, OFS_INT_SOURCE_MASK,
      OFS_CURRENT_INT_CAPTURE, OFS_IRQ_STATUS, OFS_IRQ_ENABLE, OFS_IRQ_CLEAR,
      OFS_GLOBAL_FIFO_BYTE_COUNT, OFS_GLOBAL_CHANNEL_NUMBER, OFS_GLOBAL_INT_TYPE,
      OFS_GLOBAL_RX_FIFO_PORT, OFS_GLOBAL_TX_FIFO_PORT, OFS_GLOBAL_RX_FILL,
      OFS_GLOBAL_TX_SPACE, OFS_GLOBAL_CHAN_STATUS, OFS_GLOBAL_BID_FIELD,
      OFS_GLOBAL_VECTOR: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // ==========================================================================
  // Interrupt context taken from the captured value.
  assign ctx_ch = cap_r[CAP_CH_BIT];
  assign ctx_type = cap_r[CAP_TYPE_MSB:CAP_TYPE_LSB];
  // One select line per channel; exactly one is high for any context.
  genvar gc;
  generate
    for (gc = 0; gc < NUM_CH; gc++)
    begin : g_ctx
      assign ctx_onehot[gc] = (int'(ctx_ch) == gc);
    end
  endgenerate
  // Only FIFO sources carry a byte count; others read zero.
  assign ctx_count = icc_is_fifo(cap_r[CAP_CODE_MSB:CAP_TYPE_LSB]) ?
                     cap_r[CAP_CNT_MSB:CAP_CNT_LSB] : 8'h00;

  // A refresh write and an acknowledge edge share one capture path.
  assign refresh = wr & (paddr == OFS_CURRENT_INT_CAPTURE);
  assign capture = ack_fall | refresh;
  assign cap_load = win_valid ? win : CAPTURE_EMPTY;

  // Capture register; it holds its value between captures.
  always_comb
  begin
    cap_nxt = cap_r;
    if (capture)
    begin
      cap_nxt = cap_load;
    end
  end

  // Vector rebuilt from the base at each capture, held otherwise.
  always_comb
  begin
    vec_nxt = vec_r;
    if (capture)
    begin
      vec_nxt = vbase_r;
      if (ctrl_r[VMOD_TYPE_BIT])
      begin
        vec_nxt[CAP_TYPE_MSB:CAP_TYPE_LSB] = cap_load[CAP_TYPE_MSB:CAP_TYPE_LSB];
      end
      if (ctrl_r[VMOD_CHAN_BIT])
      begin
        vec_nxt[CAP_CH_BIT] = cap_load[CAP_CH_BIT];
      end
    end
  end

  // ==========================================================================
  // Writable registers and the clear strobe of the interrupt status.
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    vbase_nxt = vbase_r;
    mask_nxt = mask_r;
    en_nxt = en_r;
    clr = '0;
    if (wr)
    begin
      unique case (paddr)
        OFS_INT_CONTROL: ctrl_nxt = pwdata[CTRL_W-1:0];
        OFS_VECTOR_BASE: vbase_nxt = pwdata[7:0];
        OFS_INT_SOURCE_MASK: mask_nxt = pwdata[NUM_SRC-1:0];
        OFS_IRQ_ENABLE: en_nxt = pwdata[NUM_EV-1:0];
        OFS_IRQ_CLEAR: clr = pwdata[NUM_EV-1:0];
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // Interrupt status events; a new event in the clearing cycle keeps its bit set.
  always_comb
  begin
    req_prev_nxt = win_valid;
    ev[EV_REQ] = win_valid & ~req_prev_r;
    ev[EV_CAP] = capture;
    ev[EV_EMPTY] = capture & ~win_valid;
    stat_nxt = (stat_r & ~clr) | ev;
  end

  // ==========================================================================
  // Global receive port pops the context channel after the access.
  always_comb
  begin
    rx_pop_nxt = '0;
    if (rd && (paddr == OFS_GLOBAL_RX_FIFO_PORT))
    begin
      rx_pop_nxt = ctx_onehot;
    end
  end

  // Global transmit port pushes its byte into the context channel.
  always_comb
  begin
    tx_push_nxt = '0;
    tx_data_nxt = tx_data_r;
    if (wr && (paddr == OFS_GLOBAL_TX_FIFO_PORT))
    begin
      tx_push_nxt = ctx_onehot;
      tx_data_nxt = pwdata[7:0];
    end
  end

  // ==========================================================================
  // Read mux; globals index the per-channel inputs by the context.
  always_comb
  begin
    rd_data = 32'h0000_0000;
    unique case (paddr)
      OFS_INT_CONTROL: rd_data[CTRL_W-1:0] = ctrl_r;
      OFS_VECTOR_BASE: rd_data[7:0] = vbase_r;
      OFS_INT_SOURCE_MASK: rd_data[NUM_SRC-1:0] = mask_r;
      OFS_CURRENT_INT_CAPTURE: rd_data[BID_W-1:0] = cap_r;
      OFS_IRQ_STATUS: rd_data[NUM_EV-1:0] = stat_r;
      OFS_IRQ_ENABLE: rd_data[NUM_EV-1:0] = en_r;
      OFS_GLOBAL_FIFO_BYTE_COUNT: rd_data[7:0] = ctx_count;
      OFS_GLOBAL_CHANNEL_NUMBER: rd_data[0] = ctx_ch;
      OFS_GLOBAL_INT_TYPE: rd_data[3:0] = ctx_type;
      OFS_GLOBAL_RX_FIFO_PORT: rd_data[7:0] = rx_data[ctx_ch*8 +: 8];
      OFS_GLOBAL_RX_FILL: rd_data[7:0] = rx_fill[ctx_ch*8 +: 8];
      OFS_GLOBAL_TX_SPACE: rd_data[7:0] = tx_space[ctx_ch*8 +: 8];
      OFS_GLOBAL_CHAN_STATUS: rd_data[7:0] = chan_status[ctx_ch*8 +: 8];
      OFS_GLOBAL_BID_FIELD: rd_data[7:0] = cap_r[CAP_CNT_MSB:CAP_CNT_LSB];
      OFS_GLOBAL_VECTOR: rd_data[7:0] = vec_r;
      default: rd_data = 32'h0000_0000;
    endcase
    prdata_nxt = (setup && !pwrite) ? rd_data : prdata_r;
  end

  // ==========================================================================
  // State registers.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_r <= CTRL_RST;
      vbase_r <= VBASE_RST;
      mask_r <= MASK_RST;
      cap_r <= CAPTURE_EMPTY;
      vec_r <= VBASE_RST;
      stat_r <= '0;
      en_r <= '0;
      req_prev_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      rx_pop_r <= '0;
      tx_push_r <= '0;
      tx_data_r <= 8'h00;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      vbase_r <= vbase_nxt;
      mask_r <= mask_nxt;
      cap_r <= cap_nxt;
      vec_r <= vec_nxt;
      stat_r <= stat_nxt;
      en_r <= en_nxt;
      req_prev_r <= req_prev_nxt;
      prdata_r <= prdata_nxt;
      rx_pop_r <= rx_pop_nxt;
      tx_push_r <= tx_push_nxt;
      tx_data_r <= tx_data_nxt;
    end
  end

  // ==========================================================================
  // Outputs.
  // Bus read data comes straight from its register.
  assign prdata = prdata_r;

  // Request and vector pins of the host side.
  assign int_request_n = ~win_valid;
  assign int_vector = vec_r;
  assign int_vector_valid = ack_active;

  // FIFO strobes and the transmit byte.
  assign rx_pop = rx_pop_r;
  assign tx_push = tx_push_r;
  assign tx_data = tx_data_r;

  // Level interrupt while any enabled status bit is set.
  assign irq = |(stat_r & en_r);

endmodule

//--- icc_pkg.sv
// Constants, register map and field layout of the interrupt context capture block.
package icc_pkg;

  // ==========================================================================
  // Sizes.
  localparam int NUM_SRC = 18;
  localparam int BID_W = 12;
  localparam int NUM_CH = 2;
  localparam int ADDR_W = 8;
  localparam int THR_W = 8;
  localparam int NUM_EV = 3;

  // ==========================================================================
  // Register byte offsets.
  localparam logic [ADDR_W-1:0] OFS_INT_CONTROL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_VECTOR_BASE = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_INT_SOURCE_MASK = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CURRENT_INT_CAPTURE = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_GLOBAL_FIFO_BYTE_COUNT = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_GLOBAL_CHANNEL_NUMBER = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_GLOBAL_INT_TYPE = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_GLOBAL_RX_FIFO_PORT = 8'h2C;
  localparam logic [ADDR_W-1:0] OFS_GLOBAL_TX_FIFO_PORT = 8'h30;
  localparam logic [ADDR_W-1:0] OFS_GLOBAL_RX_FILL = 8'h34;
  localparam logic [ADDR_W-1:0] OFS_GLOBAL_TX_SPACE = 8'h38;
  localparam logic [ADDR_W-1:0] OFS_GLOBAL_CHAN_STATUS = 8'h3C;
  localparam logic [ADDR_W-1:0] OFS_GLOBAL_BID_FIELD = 8'h40;
  localparam logic [ADDR_W-1:0] OFS_GLOBAL_VECTOR = 8'h44;

  // ==========================================================================
  // Field positions.
  localparam int THR_LSB = 0;
  localparam int THR_MSB = 7;
  localparam int VMOD_TYPE_BIT = 8;
  localparam int VMOD_CHAN_BIT = 9;
  localparam int CTRL_W = 10;
  localparam int CAP_CH_BIT = 0;
  localparam int CAP_TYPE_LSB = 1;
  localparam int CAP_TYPE_MSB = 4;
  localparam int CAP_CODE_MSB = 3;
  localparam int CAP_CNT_LSB = 4;
  localparam int CAP_CNT_MSB = 11;
  localparam int EV_REQ = 0;
  localparam int EV_CAP = 1;
  localparam int EV_EMPTY = 2;

  // ==========================================================================
  // Reset values and special codes.
  localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;
  localparam logic [7:0] VBASE_RST = 8'h00;
  localparam logic [NUM_SRC-1:0] MASK_RST = 18'h00000;
  localparam logic [BID_W-1:0] CAPTURE_EMPTY = 12'h000;
  localparam logic [3:0] TYPE_NONE = 4'h0;
  localparam logic [2:0] CODE_RX_OK = 3'h1;
  localparam logic [2:0] CODE_RX_ERR = 3'h5;
  localparam logic [2:0] CODE_RX_WDOG = 3'h4;
  localparam logic [2:0] CODE_TX = 3'h2;

  // True when bid bits three to one name a FIFO source.
  function automatic logic icc_is_fifo(input logic [2:0] code);
    icc_is_fifo = (code == CODE_RX_OK) || (code == CODE_RX_ERR) ||
                  (code == CODE_RX_WDOG) || (code == CODE_TX);
  endfunction

endpackage

//--- icc_ack_sync.sv
// Acknowledge pin synchroniser with falling edge detection.
`timescale 1ns/1ps
module icc_ack_sync
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic int_ack_n,
  output logic ack_active,
  output logic ack_fall
);
  import icc_pkg::*;

  logic meta_r;
  logic sync_r;
  logic prev_r;
  logic meta_nxt;
  logic sync_nxt;
  logic prev_nxt;

  // Two stages resolve metastability; the third remembers the last level.
  always_comb
  begin
    meta_nxt = int_ack_n;
    sync_nxt = meta_r;
    prev_nxt = sync_r;
  end

  // Idle level of the pin is high, so reset to high.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
      prev_r <= 1'b1;
    end
    else
    begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      prev_r <= prev_nxt;
    end
  end

  // One pulse per falling edge, however long the pin stays low.
  assign ack_fall = prev_r & ~sync_r;
  assign ack_active = ~sync_r;

endmodule

//--- icc_arbiter.sv
// Half-rate bid arbiter that keeps the latest winning bid.
`timescale 1ns/1ps
module icc_arbiter
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [icc_pkg::NUM_SRC*icc_pkg::BID_W-1:0] bids,
  input wire logic [icc_pkg::NUM_SRC-1:0] src_mask,
  input wire logic [icc_pkg::THR_W-1:0] threshold,
  output logic [icc_pkg::BID_W-1:0] win,
  output logic win_valid
);
  import icc_pkg::*;

  logic phase_r;
  logic phase_nxt;
  logic [NUM_SRC*BID_W-1:0] hold_r;
  logic [NUM_SRC*BID_W-1:0] hold_nxt;
  logic [BID_W-1:0] win_r;
  logic [BID_W-1:0] win_nxt;
  logic valid_r;
  logic valid_nxt;
  logic [BID_W-1:0] masked [NUM_SRC];
  logic [BID_W-1:0] best;
  logic [BID_W-2:0] thr_ext;

  // Threshold bit zero lines up with bid bit four.
  assign thr_ext = {threshold, 3'h0};

  // Sources that are disabled or not above threshold bid zero.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_SRC; gi++)
    begin : g_src
      logic [BID_W-1:0] b;
      assign b = hold_r[gi*BID_W +: BID_W];
      assign masked[gi] = (src_mask[gi] && (b[BID_W-1:1] > thr_ext)) ? b : CAPTURE_EMPTY;
    end
  endgenerate

  // Highest bid wins; the channel bit breaks ties toward channel B.
  always_comb
  begin
    best = CAPTURE_EMPTY;
    for (int i = 0; i < NUM_SRC; i++)
    begin
      if (masked[i] > best)
      begin
        best = masked[i];
      end
    end
  end

  // Bids are latched in one phase and judged in the next.
  always_comb
  begin
    phase_nxt = ~phase_r;
    hold_nxt = phase_r ? hold_r : bids;
    win_nxt = phase_r ? best : win_r;
    valid_nxt = phase_r ? (best != CAPTURE_EMPTY) : valid_r;
  end

  // Arbiter state registers.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase_r <= 1'b0;
      hold_r <= '0;
      win_r <= CAPTURE_EMPTY;
      valid_r <= 1'b0;
    end
    else
    begin
      phase_r <= phase_nxt;
      hold_r <= hold_nxt;
      win_r <= win_nxt;
      valid_r <= valid_nxt;
    end
  end

  assign win = win_r;
  assign win_valid = valid_r;

endmodule

//--- icc_host_model.sv
// Host side model that drives the acknowledge pin of the capture block.
`timescale 1ns/1ps
module icc_host_model
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ack_req,
  output logic int_ack_n
);
  // ==========================================================================
  // Acknowledge pin
  // The pin stays low for as long as the bench asks for an acknowledge cycle.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      int_ack_n <= 1'b1;
    else
      int_ack_n <= !ack_req;
  end
endmodule

//--- icc_top_properties.sv
// Checker of port timing for the interrupt context capture top.
`timescale 1ns/1ps
module icc_top_properties
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [icc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  input wire logic int_ack_n,
  input wire logic [7:0] int_vector,
  input wire logic int_vector_valid,
  input wire logic [icc_pkg::NUM_CH-1:0] rx_pop,
  input wire logic [icc_pkg::NUM_CH-1:0] tx_push,
  input wire logic [7:0] tx_data
);
  import icc_pkg::*;
  logic rd_rx;
  logic wr_tx;
  logic any_wr;

  // ==========================================================================
  // Completed bus accesses of interest.
  assign rd_rx = psel && penable && !pwrite && paddr == OFS_GLOBAL_RX_FIFO_PORT;
  assign wr_tx = psel && penable && pwrite && paddr == OFS_GLOBAL_TX_FIFO_PORT;
  assign any_wr = psel && penable && pwrite;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  // ==========================================================================
  // Assertions.
  ack_vec_rise_a: assert property ($fell(int_ack_n) |-> ##[1:4] int_vector_valid)
    else $error("vector valid did not follow acknowledge");
  ack_vec_fall_a: assert property ($rose(int_ack_n) |-> ##[1:4] !int_vector_valid)
    else $error("vector valid did not end with acknowledge");
  rx_pop_a: assert property (rd_rx |=> $onehot(rx_pop))
    else $error("global receive read gave no single pop");
  tx_push_a: assert property (wr_tx |=> $onehot(tx_push) && tx_data == $past(pwdata[7:0]))
    else $error("global transmit write gave wrong push");
  pop_cause_a: assert property (rx_pop != 2'b00 |-> $past(rd_rx))
    else $error("pop without global receive read");
  push_cause_a: assert property (tx_push != 2'b00 |-> $past(wr_tx))
    else $error("push without global transmit write");
  vector_hold_a: assert property ($changed(int_vector) |->
    $past(any_wr) || $past(any_wr, 2) || (int_vector_valid && !$past(int_vector_valid, 2)))
    else $error("vector changed without capture");
  one_capture_a: assert property (int_vector_valid && $past(int_vector_valid, 3) &&
    !$past(any_wr) && !$past(any_wr, 2) |-> $stable(int_vector))
    else $error("second capture within one acknowledge");
  global_map_a: assert property (wr_tx |-> !pslverr)
    else $error("global port flagged as unmapped");
endmodule

bind icc_top icc_top_properties i_props (.mclk(mclk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
  .int_ack_n(int_ack_n), .int_vector(int_vector), .int_vector_valid(int_vector_valid),
  .rx_pop(rx_pop), .tx_push(tx_push), .tx_data(tx_data));

//--- icc_top_test.sv
// Self-checking bench of the interrupt context capture top.
`timescale 1ns/1ps
module icc_top_test;
  import icc_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [NUM_SRC*BID_W-1:0] bids = '0;
  logic [15:0] rx_data = 16'hB1A0;
  logic [15:0] rx_fill = 16'h2717;
  logic [15:0] tx_space = 16'h4536;
  logic [15:0] chan_status = 16'h6958;
  logic ack_req = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, int_ack_n, int_request_n, int_vector_valid, irq;
  logic [7:0] int_vector, tx_data;
  logic [1:0] rx_pop, tx_push;
  logic [31:0] q;
  logic e;
  logic [1:0] pop_seen = 2'h0;
  logic [1:0] push_seen = 2'h0;
  logic [11:0] tab [3] = '{12'h053, 12'h224, 12'h711};
  int srcs [3] = '{3, 5, 17};
  int error_cnt = 0;
  int total_checks = 0;
  int cycles = 0;

  icc_top i_dut (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .int_ack_n(int_ack_n), .int_request_n(int_request_n), .int_vector(int_vector),
    .int_vector_valid(int_vector_valid), .bids(bids), .rx_data(rx_data), .rx_fill(rx_fill),
    .tx_space(tx_space), .chan_status(chan_status), .rx_pop(rx_pop), .tx_push(tx_push),
    .tx_data(tx_data), .irq(irq));
  icc_host_model i_host (.mclk(mclk), .rst_n(rst_n), .ack_req(ack_req), .int_ack_n(int_ack_n));

  // ==========================================================================
  // Clock and a cycle ceiling that cuts a hang short.
  always #12.5 mclk = ~mclk;
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      error_cnt++;
      report_and_stop();
    end
  end

  // FIFO strobes are one-cycle pulses; remember the last one at the falling edge.
  always @(negedge mclk)
  begin
    if (rx_pop != 2'h0)
      pop_seen <= rx_pop;
    if (tx_push != 2'h0)
      push_seen <= tx_push;
  end

  // ==========================================================================
  // Tasks.
  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      $display("[ERR] %s expected %h seen %h", name, exp, got);
      error_cnt++;
    end
  endtask
  // One transfer; the request is held until pready is seen high at an edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(name, exp, q);
  endtask
  // Presents one nonzero bid and gives the arbiter time to settle.
  task automatic set_bid(input int src, input logic [11:0] v);
    logic [NUM_SRC*BID_W-1:0] b;
    b = '0;
    b[src*BID_W +: BID_W] = v;
    bids <= b;
    repeat (6) @(posedge mclk);
  endtask
  task automatic ack(input logic [7:0] exp);
    int n;
    n = 0;
    ack_req <= 1'b1;
    while (int_vector_valid !== 1'b1 && n < 10)
    begin
      @(posedge mclk);
      n++;
    end
    @(posedge mclk);
    chk("vector", exp, int_vector);
  endtask
  task automatic ack_end;
    ack_req <= 1'b0;
    repeat (6) @(posedge mclk);
  endtask
  function automatic logic [7:0] fifo_cnt(input logic [11:0] v);
    return (v[3:1] inside {3'h1, 3'h5, 3'h4, 3'h2}) ? v[11:4] : 8'h00;
  endfunction

  // ==========================================================================
  // Main sequence.
  initial
  begin
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    rd_chk("reset capture", OFS_CURRENT_INT_CAPTURE, 32'h0);
    apb(1'b0, 8'h4C, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, q);
    apb(1'b1, OFS_IRQ_ENABLE, 32'h6);
    apb(1'b1, OFS_CURRENT_INT_CAPTURE, 32'hFFFFFFFF);
    rd_chk("empty capture", OFS_CURRENT_INT_CAPTURE, 32'h0);
    rd_chk("empty type", OFS_GLOBAL_INT_TYPE, 32'h0);
    rd_chk("status", OFS_IRQ_STATUS, 32'h6);
    chk("irq high", 32'h1, {31'h0, irq});
    apb(1'b1, OFS_IRQ_CLEAR, 32'h6);
    rd_chk("status clear", OFS_IRQ_STATUS, 32'h0);
    chk("irq low", 32'h0, {31'h0, irq});
    apb(1'b1, OFS_INT_SOURCE_MASK, 32'h3FFFF);
    for (int k = 0; k < 3; k++)
    begin
      set_bid(srcs[k], tab[k]);
      chk("request", 32'h0, {31'h0, int_request_n});
      apb(1'b1, OFS_CURRENT_INT_CAPTURE, 32'h0);
      rd_chk("capture", OFS_CURRENT_INT_CAPTURE, {20'h0, tab[k]});
      rd_chk("channel", OFS_GLOBAL_CHANNEL_NUMBER, {31'h0, tab[k][0]});
      rd_chk("type", OFS_GLOBAL_INT_TYPE, {28'h0, tab[k][4:1]});
      rd_chk("count", OFS_GLOBAL_FIFO_BYTE_COUNT, {24'h0, fifo_cnt(tab[k])});
      rd_chk("rx port", OFS_GLOBAL_RX_FIFO_PORT, {24'h0, rx_data[tab[k][0]*8 +: 8]});
      chk("pop channel", {30'h0, tab[k][0], ~tab[k][0]}, {30'h0, pop_seen});
      rd_chk("rx fill", OFS_GLOBAL_RX_FILL, {24'h0, rx_fill[tab[k][0]*8 +: 8]});
      rd_chk("tx space", OFS_GLOBAL_TX_SPACE, {24'h0, tx_space[tab[k][0]*8 +: 8]});
      rd_chk("chan status", OFS_GLOBAL_CHAN_STATUS,
        {24'h0, chan_status[tab[k][0]*8 +: 8]});
      rd_chk("bid field", OFS_GLOBAL_BID_FIELD, {24'h0, tab[k][11:4]});
      apb(1'b1, OFS_GLOBAL_TX_FIFO_PORT, 32'h5A + k);
      chk("push channel", {30'h0, tab[k][0], ~tab[k][0]}, {30'h0, push_seen});
      chk("tx data", 32'h5A + k, {24'h0, tx_data});
    end
    set_bid(3, tab[0]);
    apb(1'b1, OFS_INT_CONTROL, 32'h5);
    repeat (4) @(posedge mclk);
    chk("above threshold", 32'h0, {31'h0, int_request_n});
    apb(1'b1, OFS_INT_CONTROL, 32'h6);
    repeat (4) @(posedge mclk);
    chk("not above", 32'h1, {31'h0, int_request_n});
    apb(1'b1, OFS_CURRENT_INT_CAPTURE, 32'h0);
    rd_chk("below capture", OFS_CURRENT_INT_CAPTURE, 32'h0);
    apb(1'b1, OFS_INT_CONTROL, 32'h300);
    apb(1'b1, OFS_VECTOR_BASE, 32'hE0);
    repeat (4) @(posedge mclk);
    ack(8'hF3);
    set_bid(5, tab[1]);
    chk("held vector", 32'hF3, {24'h0, int_vector});
    rd_chk("held capture", OFS_CURRENT_INT_CAPTURE, {20'h0, tab[0]});
    rd_chk("global vector", OFS_GLOBAL_VECTOR, 32'hF3);
    ack_end();
    apb(1'b1, OFS_INT_SOURCE_MASK, 32'h0);
    repeat (4) @(posedge mclk);
    ack(8'hE0);
    ack_end();
    rd_chk("ack empty", OFS_CURRENT_INT_CAPTURE, 32'h0);
    apb(1'b1, OFS_INT_CONTROL, 32'h0);
    apb(1'b1, OFS_INT_SOURCE_MASK, 32'h3FFFF);
    repeat (4) @(posedge mclk);
    ack(8'hE0);
    ack_end();
    rd_chk("ack capture", OFS_CURRENT_INT_CAPTURE, {20'h0, tab[1]});
    report_and_stop();
  end
endmodule
